// ==== include/twbea_map.svh ====
`ifndef TWBEA_MAP_SVH
`define TWBEA_MAP_SVH
// Register byte offsets
`define TWBEA_CTRL_OFF    8'h00
`define TWBEA_STAT_OFF    8'h04
`define TWBEA_DATA_OFF    8'h08
`define TWBEA_ADDR_OFF    8'h0c
`define TWBEA_IRQS_OFF    8'h10
`define TWBEA_IRQM_OFF    8'h14
// Control fields
`define TWBEA_C_INT       7
`define TWBEA_C_EA        6
`define TWBEA_C_STA       5
`define TWBEA_C_STO       4
`define TWBEA_C_EN        2
// Status codes, prescaler bits taken as zero
`define TWBEA_ST_IDLE     8'hf8
`define TWBEA_ST_BERR     8'h00
`define TWBEA_ST_ARB_LOST 8'h38
`define TWBEA_ST_SR_ARB   8'h68
`define TWBEA_ST_ST_ARB   8'hb0
`define TWBEA_ST_SR_ADDR  8'h60
`define TWBEA_ST_ST_ADDR  8'ha8
`define TWBEA_ST_NOTADDR  8'h20
`define TWBEA_PRESC_MASK  8'hf8
// Interrupt status bits
`define TWBEA_I_DONE      0
`define TWBEA_I_BERR      1
`define TWBEA_I_ARB       2
`endif

// ==== include/twbea_pkg.sv ====
package twbea_pkg;
  typedef enum logic [4:0] {
    TWBEA_IDLE  = 5'b00001,
    TWBEA_ADDR  = 5'b00010,
    TWBEA_DATA  = 5'b00100,
    TWBEA_ACK   = 5'b01000,
    TWBEA_WAIT  = 5'b10000
  } twbea_state_t;
  typedef enum logic [1:0] {
    TWBEA_HTR_IDLE = 2'b00,
    TWBEA_HTR_BUSY = 2'b01,
    TWBEA_HTR_NSEQ = 2'b10,
    TWBEA_HTR_SEQ  = 2'b11
  } twbea_htrans_t;
endpackage

// ==== src/twbea_core.sv ====
`timescale 1ns/100ps
`include "twbea_map.svh"
module twbea_core
  import twbea_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             irq
);
  import twbea_pkg::*;

  typedef struct packed {
    logic [1:0]   scl_s;
    logic [1:0]   sda_s;
    logic         scl_p;
    logic         sda_p;
    twbea_state_t st;
    logic [3:0]   bitn;
    logic [7:0]   sh;
    logic         master;
    logic         first;
    logic         tx;
    logic         done;
    logic         ea;
    logic         start_request_bit;
    logic         stop_request_column;
    logic         en;
    logic [7:0]   status;
    logic [7:0]   data;
    logic [6:0]   own;
    logic         drive_low;
    logic         hold_scl;
    logic [2:0]   irqs;
    logic [2:0]   irqm;
    logic         wr_ph;
    logic [7:0]   ad_ph;
    logic [31:0]  rdata;
  } twbea_regs_t;

  twbea_regs_t q;
  twbea_regs_t d;

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic wr_ctrl;
  logic rd_go;
  logic [7:0] ctl_val;
  logic bus_err;
  logic arb_lost;

  assign scl = q.scl_s[1];
  assign sda = q.sda_s[1];
  assign scl_rise = scl & ~q.scl_p;
  assign scl_fall = ~scl & q.scl_p;
  assign start_c = scl & q.scl_p & q.sda_p & ~sda;
  assign stop_c  = scl & q.scl_p & ~q.sda_p & sda;
  assign wr_ctrl = q.wr_ph && q.ad_ph == `TWBEA_CTRL_OFF;
  assign rd_go   = hsel && hready && htrans == TWBEA_HTR_NSEQ && !hwrite;
  // ****************************************
  // Frame errors and arbitration
  // ****************************************
  // First bit slot of a byte is where STOP or repeated START legally sits
  assign bus_err  = (start_c || stop_c) && q.st != TWBEA_IDLE && q.st != TWBEA_WAIT
                    && !((q.st == TWBEA_ADDR || q.st == TWBEA_DATA) && q.bitn <= 4'h1);
  // Wire and-ing means a match never trips this
  assign arb_lost = scl_rise && q.master && q.tx && !q.drive_low && !sda
                    && (q.st == TWBEA_ADDR || q.st == TWBEA_DATA);

  assign ctl_val = {q.done, q.ea, q.start_request_bit, q.stop_request_column, 1'b0, q.en, 2'b00};

  always_comb begin
    d = q;
    d.scl_s = {q.scl_s[0], scl_i};
    d.sda_s = {q.sda_s[0], sda_i};
    d.scl_p = scl;
    d.sda_p = sda;
    // ****************************************
    // Bus register writes
    // ****************************************
    d.wr_ph = hsel && hready && htrans == TWBEA_HTR_NSEQ && hwrite;
    d.ad_ph = haddr[7:0];
    if (q.wr_ph) begin
      case (q.ad_ph)
        `TWBEA_CTRL_OFF: begin
          d.ea  = hwdata[`TWBEA_C_EA];
          d.start_request_bit = hwdata[`TWBEA_C_STA];
          d.stop_request_column = hwdata[`TWBEA_C_STO];
          d.en  = hwdata[`TWBEA_C_EN];
          if (hwdata[`TWBEA_C_INT]) begin
            d.done = 1'b0;
            d.hold_scl = 1'b0;
          end
        end
        `TWBEA_DATA_OFF: d.data = hwdata[7:0];
        `TWBEA_ADDR_OFF: d.own  = hwdata[6:0];
        `TWBEA_IRQS_OFF: d.irqs = q.irqs & ~hwdata[2:0];
        `TWBEA_IRQM_OFF: d.irqm = hwdata[2:0];
        default: ;
      endcase
    end
    // Software response to a flagged state
    if (wr_ctrl && hwdata[`TWBEA_C_INT] && q.done) begin
      if (q.status == `TWBEA_ST_BERR && hwdata[`TWBEA_C_STO]) begin
        // Internal only: lines let go, no STOP driven
        d.st = TWBEA_IDLE;
        d.master = 1'b0;
        d.stop_request_column = 1'b0;
        d.drive_low = 1'b0;
        d.hold_scl = 1'b0;
      end else if ((q.status & `TWBEA_PRESC_MASK) == `TWBEA_ST_ARB_LOST
                   || (q.status & `TWBEA_PRESC_MASK) == `TWBEA_ST_NOTADDR) begin
        d.st = hwdata[`TWBEA_C_STA] ? TWBEA_WAIT : TWBEA_IDLE;
        d.master = 1'b0;
      end else if (q.master && hwdata[`TWBEA_C_STA] && q.st == TWBEA_ACK) begin
        // Repeated start: release SCL, keep ownership
        d.st = TWBEA_ADDR;
        d.bitn = 4'h0;
        d.sh = q.data;
        d.tx = 1'b1;
        d.first = 1'b1;
      end
    end
    // ****************************************
    // Bit engine
    // ****************************************
    if (q.en) begin
      if (start_c && !bus_err) begin
        d.st = TWBEA_ADDR;
        d.bitn = 4'h0;
        d.first = 1'b1;
        d.tx = q.master && q.st == TWBEA_ADDR;
      end else if (scl_rise && (q.st == TWBEA_ADDR || q.st == TWBEA_DATA)) begin
        d.sh = {q.sh[6:0], sda};
        d.bitn = q.bitn + 4'h1;
      end else if (scl_fall && q.bitn == 4'h8 && q.st != TWBEA_ACK) begin
        d.st = TWBEA_ACK;
        d.bitn = 4'h0;
        if (q.st == TWBEA_ADDR && !q.master) begin
          if (q.ea && q.sh[7:1] == q.own) begin
            d.drive_low = 1'b1;
            d.done = 1'b1;
            d.status = q.sh[0] ? `TWBEA_ST_ST_ADDR : `TWBEA_ST_SR_ADDR;
            if (q.status == `TWBEA_ST_ARB_LOST)
              d.status = q.sh[0] ? `TWBEA_ST_ST_ARB : `TWBEA_ST_SR_ARB;
            d.tx = q.sh[0];
          end else if (q.status == `TWBEA_ST_ARB_LOST) begin
            d.done = 1'b1;
            d.status = `TWBEA_ST_NOTADDR;
          end
        end
      end else if (scl_fall && q.st == TWBEA_ACK) begin
        d.drive_low = 1'b0;
        d.st = TWBEA_DATA;
        // Next value, so a same-cycle flag clear never leaves SCL held
        d.hold_scl = d.done;
      end
    end
    if (arb_lost) begin
      d.master = 1'b0;
      d.tx = 1'b0;
      d.status = `TWBEA_ST_ARB_LOST;
      // Stay in address phase as a listening slave
      if (q.st == TWBEA_ADDR) begin
        d.st = TWBEA_ADDR;
      end else begin
        d.done = 1'b1;
        d.st = TWBEA_WAIT;
      end
    end
    if (q.st == TWBEA_WAIT && stop_c && q.start_request_bit) d.st = TWBEA_IDLE;
    if (bus_err && q.en) begin
      d.status = `TWBEA_ST_BERR;
      d.done = 1'b1;
      d.st = TWBEA_WAIT;
    end
    if (stop_c && q.st != TWBEA_WAIT) d.st = TWBEA_IDLE;
    // ****************************************
    // Interrupt status, set beats clear
    // ****************************************
    if (d.done && !q.done) d.irqs[`TWBEA_I_DONE] = 1'b1;
    if (bus_err && q.en)   d.irqs[`TWBEA_I_BERR] = 1'b1;
    if (arb_lost)          d.irqs[`TWBEA_I_ARB]  = 1'b1;
    // ****************************************
    // Read data
    // ****************************************
    d.rdata = 32'h0000_0000;
    if (rd_go) begin
      case (haddr[7:0])
        `TWBEA_CTRL_OFF: d.rdata = {24'h00_0000, ctl_val};
        `TWBEA_STAT_OFF: d.rdata = {24'h00_0000, d.done ? d.status : `TWBEA_ST_IDLE};
        `TWBEA_DATA_OFF: d.rdata = {24'h00_0000, q.sh};
        `TWBEA_ADDR_OFF: d.rdata = {25'h000_0000, q.own};
        `TWBEA_IRQS_OFF: d.rdata = {29'h0000_0000, d.irqs};
        `TWBEA_IRQM_OFF: d.rdata = {29'h0000_0000, q.irqm};
        default:         d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{scl_s: 2'b11, sda_s: 2'b11, scl_p: 1'b1, sda_p: 1'b1, st: TWBEA_IDLE,
             status: `TWBEA_ST_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign hrdata    = q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign scl_o     = 1'b0;
  assign scl_oe    = q.hold_scl;
  assign sda_o     = 1'b0;
  assign sda_oe    = q.drive_low;
  assign irq       = |(q.irqs & q.irqm);

  // ****************************************
  // Checks
  // ****************************************
  a_idle_code_shown: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_go && haddr[7:0] == `TWBEA_STAT_OFF && !d.done |=> hrdata[7:0] == `TWBEA_ST_IDLE)
    else $error("status not idle code while done clear");
  a_berr_sets_done: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_err && q.en |=> q.done && q.status == `TWBEA_ST_BERR)
    else $error("bus error did not flag");
  a_recover_release: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl && hwdata[`TWBEA_C_INT] && hwdata[`TWBEA_C_STO] && q.done && q.status == `TWBEA_ST_BERR
    |=> !q.stop_request_column && !q.master && !sda_oe && !scl_oe)
    else $error("bus error recovery wrong");
  a_arb_drops_master: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_lost |=> !q.master && q.status == `TWBEA_ST_ARB_LOST)
    else $error("arbitration loss not taken");
  a_arb_addr_slave: assert property (@(posedge hclk) disable iff (!hresetn)
    arb_lost && q.st == TWBEA_ADDR |=> q.st == TWBEA_ADDR && !q.done)
    else $error("lost in address did not listen");
  a_no_ack_ea_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !q.ea && !q.master && !q.drive_low |=> !q.drive_low)
    else $error("acked with ack enable off");
  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(irq) |-> $past(d.irqs & d.irqm) != 3'h0)
    else $error("irq without cause");
  a_berr_needs_err: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(q.irqs[`TWBEA_I_BERR]) |-> $past(bus_err))
    else $error("bus error flag without event");

  // ****************************************
  // Recovery and register checks
  // ****************************************
  a_recover_to_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl && hwdata[`TWBEA_C_INT] && hwdata[`TWBEA_C_STO] && q.done && q.status == `TWBEA_ST_BERR
    && !start_c |=> q.st == TWBEA_IDLE)
    else $error("recovery did not enter not addressed slave");

  // Only the stop request self-clears
  a_recover_ctrl_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl && hwdata[`TWBEA_C_INT] && hwdata[`TWBEA_C_STO] && q.done && q.status == `TWBEA_ST_BERR
    |=> q.ea == $past(hwdata[`TWBEA_C_EA]) && q.en == $past(hwdata[`TWBEA_C_EN]))
    else $error("recovery altered other control bits");

  a_status_masked: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_go && haddr[7:0] == `TWBEA_STAT_OFF
    |=> (hrdata[7:0] & ~`TWBEA_PRESC_MASK) == 8'h00)
    else $error("status shows prescaler bits");

  // Read data stands for its data phase only
  a_rdata_zero_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_go |=> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");

  a_ready_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hsel |-> hreadyout && !hresp)
    else $error("bus answer not ready or not okay");

  // ****************************************
  // Link and flag checks
  // ****************************************
  a_rep_start_addr: assert property (@(posedge hclk) disable iff (!hresetn)
    q.en && start_c && !bus_err
    |=> q.st == TWBEA_ADDR && q.bitn == 4'h0)
    else $error("repeated start not taken as address");

  // Ack only on own address with acks enabled
  a_ack_own_only: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(sda_oe)
    |-> $past(q.ea) && $past(q.sh[7:1]) == $past(q.own))
    else $error("ack without own address");

  // Clock stretch lasts only while software owes an answer
  a_hold_needs_done: assert property (@(posedge hclk) disable iff (!hresetn)
    scl_oe |-> q.done)
    else $error("scl held with flag clear");

  a_berr_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_err && q.en |=> q.irqs[`TWBEA_I_BERR])
    else $error("bus error event lost");

  a_done_raises_irqs: assert property (@(posedge hclk) disable iff (!hresetn)
    !q.done && d.done |=> q.irqs[`TWBEA_I_DONE])
    else $error("done event lost");

  // Set wins over a same-cycle clear
  a_irqs_cleared: assert property (@(posedge hclk) disable iff (!hresetn)
    q.wr_ph && q.ad_ph == `TWBEA_IRQS_OFF && hwdata[`TWBEA_I_DONE] && !(d.done && !q.done)
    |=> !q.irqs[`TWBEA_I_DONE])
    else $error("write one did not clear");
endmodule // twbea_core

// ==== tb/twbea_tb_peer.sv ====
`timescale 1ns/100ps
// ****************************************
// Far-side bus party, open drain, pull-up
// ****************************************
module twbea_tb_peer (
  output logic      scl_low,
  output logic      sda_low,
  input  wire logic sda_line
);
  localparam realtime HALF = 62.5;
  // Released lines float high by the pull-up, never hold old values
  initial begin
    scl_low = 1'h0;
    sda_low = 1'h0;
  end
  task automatic start_cond();
    sda_low = 1'h1;
    #HALF;
    scl_low = 1'h1;
    #HALF;
  endtask
  // Called with SCL low after an ack slot
  task automatic rep_start();
    sda_low = 1'h0;
    #HALF;
    scl_low = 1'h0;
    #HALF;
    sda_low = 1'h1;
    #HALF;
    scl_low = 1'h1;
    #HALF;
  endtask
  task automatic send_bit(input logic b);
    sda_low = !b;
    #HALF;
    scl_low = 1'h0;
    #HALF;
    scl_low = 1'h1;
  endtask
  // Ack sampled mid-high; clock stops low afterwards
  task automatic send_byte(input logic [7:0] v, output logic acked);
    for (int i = 7; i >= 0; i--) begin
      send_bit(v[i]);
    end
    sda_low = 1'h0;
    #HALF;
    scl_low = 1'h0;
    #(HALF / 2);
    acked = !sda_line;
    #(HALF / 2);
    scl_low = 1'h1;
  endtask
  task automatic stop_cond();
    sda_low = 1'h1;
    #HALF;
    scl_low = 1'h0;
    #HALF;
    sda_low = 1'h0;
    #HALF;
  endtask
endmodule // twbea_tb_peer

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`include "twbea_map.svh"
module tb_top;
  import twbea_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        scl_o, scl_oe, sda_o, sda_oe, irq;
  logic        p_scl_low, p_sda_low, acked, ea, rw;
  logic [6:0]  own;
  int          n_errors, cmp_count, cycles, lows;
  wire         scl_line = !((scl_oe && !scl_o) || p_scl_low);
  wire         sda_line = !((sda_oe && !sda_o) || p_sda_low);

  twbea_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  twbea_tb_peer peer (.scl_low(p_scl_low), .sda_low(p_sda_low), .sda_line(sda_line));

  always #4 hclk = !hclk;
  // ****************************************
  // Checks, bus cycles, expectations
  // ****************************************
  task automatic end_of_test();
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= TWBEA_HTR_NSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= TWBEA_HTR_IDLE;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask
  function automatic logic [31:0] ctrl_after_recovery(input logic a);
    return {24'h0, 1'h0, a, 6'h04};
  endfunction
  function automatic logic [31:0] own_code(input logic dir);
    return dir ? 32'(`TWBEA_ST_ST_ADDR) : 32'(`TWBEA_ST_SR_ADDR);
  endfunction
  // Hang guard, run needs well under 10k cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    hclk = 1'h0; hresetn = 1'h0; hsel = 1'h0; hwrite = 1'h0; haddr = 32'h0; hwdata = 32'h0;
    htrans = TWBEA_HTR_IDLE; hsize = 3'h2; n_errors = 0; cmp_count = 0; cycles = 0;
    rd = $urandom(11549);
    own = 7'($urandom_range(119, 8));
    ea = 1'($urandom());
    rw = 1'($urandom());
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    ahb(1'h0, `TWBEA_STAT_OFF, 32'h0, rd);
    check(rd & 32'(`TWBEA_PRESC_MASK), 32'(`TWBEA_ST_IDLE));
    check(32'(irq), 32'h0);
    ahb(1'h0, 8'h20, 32'h0, rd);
    check(rd, 32'h0);
    ahb(1'h1, `TWBEA_ADDR_OFF, {25'h0, own}, rd);
    ahb(1'h1, `TWBEA_CTRL_OFF, 32'h04, rd);
    // Own address with ack disabled must go unanswered
    peer.start_cond();
    peer.send_byte({own, 1'h0}, acked);
    check(32'(acked), 32'h0);
    // Address write turned into a read by a repeated start, no STOP between
    peer.rep_start();
    peer.send_byte({own, 1'h1}, acked);
    check(32'(acked), 32'h0);
    peer.stop_cond();
    ahb(1'h0, `TWBEA_STAT_OFF, 32'h0, rd);
    check(rd & 32'hf8, 32'(`TWBEA_ST_IDLE));
    // STOP in mid address byte
    ahb(1'h1, `TWBEA_IRQM_OFF, 32'h2, rd);
    peer.start_cond();
    repeat (3) peer.send_bit(1'($urandom()));
    peer.stop_cond();
    repeat (6) @(posedge hclk);
    ahb(1'h0, `TWBEA_STAT_OFF, 32'h0, rd);
    check(rd & 32'hf8, 32'(`TWBEA_ST_BERR));
    ahb(1'h0, `TWBEA_CTRL_OFF, 32'h0, rd);
    check(rd & 32'h80, 32'h80);
    check(32'(irq), 32'h1);
    ahb(1'h1, `TWBEA_IRQM_OFF, 32'h0, rd);
    repeat (3) @(posedge hclk);
    check(32'(irq), 32'h0);
    ahb(1'h1, `TWBEA_CTRL_OFF, {24'h0, 1'h1, ea, 6'h14}, rd);
    lows = 0;
    repeat (40) begin
      @(posedge hclk);
      if (sda_line !== 1'h1 || scl_line !== 1'h1) lows++;
    end
    check(32'(lows), 32'h0);
    ahb(1'h0, `TWBEA_CTRL_OFF, 32'h0, rd);
    check(rd & 32'hf4, ctrl_after_recovery(ea));
    ahb(1'h0, `TWBEA_STAT_OFF, 32'h0, rd);
    check(rd & 32'hf8, 32'(`TWBEA_ST_IDLE));
    ahb(1'h0, `TWBEA_IRQS_OFF, 32'h0, rd);
    check(rd & 32'h2, 32'h2);
    ahb(1'h1, `TWBEA_IRQS_OFF, 32'h7, rd);
    ahb(1'h0, `TWBEA_IRQS_OFF, 32'h0, rd);
    check(rd & 32'h7, 32'h0);
    // Ack enabled again: own address is answered
    ahb(1'h1, `TWBEA_IRQM_OFF, 32'h1, rd);
    ahb(1'h1, `TWBEA_CTRL_OFF, 32'h44, rd);
    peer.start_cond();
    peer.send_byte({own, rw}, acked);
    check(32'(acked), 32'h1);
    repeat (6) @(posedge hclk);
    ahb(1'h0, `TWBEA_STAT_OFF, 32'h0, rd);
    check(rd & 32'hf8, own_code(rw));
    check(32'(irq), 32'h1);
    end_of_test();
  end
endmodule // tb_top
